/* File: hdl/hsc_consts.vh */
// Purpose: Shared constants of the high-speed counter bank.
// Assumes: 10 MHz system clock.
// Notes:   Type, mode and timing codes used by the bank and its channels.
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH

// Counter types.
`define HSC_T_DIS    3'h0
`define HSC_T_FREQ   3'h1
`define HSC_T_TOT    3'h2
`define HSC_T_PULSE  3'h3
`define HSC_T_QUAD   3'h4
`define HSC_T_MARK   3'h5

// Frequency gate modes.
`define HSC_M_G1S    4'h0
`define HSC_M_G100MS 4'h1
`define HSC_M_G10MS  4'h2
`define HSC_M_GSCAN  4'h3

// Totalize modes.
`define HSC_M_RISE   4'h0
`define HSC_M_FALL   4'h1

// Pulse modes.
`define HSC_M_WHIGH  4'h0
`define HSC_M_WLOW   4'h1
`define HSC_M_PRISE  4'h2
`define HSC_M_PFALL  4'h3

// Quadrature modes.
`define HSC_M_QUP    4'h0
`define HSC_M_QDOWN  4'h1

// Marker modes.
`define HSC_M_ARISE  4'h0
`define HSC_M_AFALL  4'h1
`define HSC_M_ABOTH  4'h2
`define HSC_M_H1R    4'h3
`define HSC_M_L1R    4'h4
`define HSC_M_H1F    4'h5
`define HSC_M_L1F    4'h6
`define HSC_M_H2R    4'h7
`define HSC_M_L2R    4'h8
`define HSC_M_H2F    4'h9
`define HSC_M_L2F    4'ha

// Timing.
`define HSC_CLK_NS   32'h64
`define HSC_US_NS    32'h3e8
`define HSC_G10MS_NS 32'h989680
`define HSC_DECADE   4'h9
`define HSC_SCALE_1S    32'h1
`define HSC_SCALE_100MS 32'ha
`define HSC_SCALE_10MS  32'h64

// Channel roles.
`define HSC_QUAD_CH  0
`define HSC_MARK_CH  2

`endif

/* File: hdl/hsc_chan.v */
// Purpose: One counter channel: frequency, totalize and pulse measurement.
// Assumes: Input level already polarity corrected and registered.
// Notes:   Quadrature and marker handling live in the bank.
`timescale 1ns/1ps
`include "hsc_consts.vh"

module hsc_chan (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Input level and time bases
  input  wire        lvl,
  input  wire        lvl_prev,
  input  wire        us_tick,
  input  wire        tick_10ms,
  input  wire        tick_100ms,
  input  wire        tick_1s,
  input  wire        scan_tick,
  // Configuration
  input  wire [2:0]  type_sel,
  input  wire [3:0]  mode_sel,
  input  wire [31:0] cpr,
  // Result
  output reg  [31:0] value_reg
);

  reg  [31:0] acc_reg;
  reg         gate;
  reg  [31:0] scale;
  reg         meas_on;
  reg         end_evt;
  wire        rise = lvl & ~lvl_prev;
  wire        fall = ~lvl & lvl_prev;
  wire [31:0] acc_inc = acc_reg + {31'h0, rise};
  wire [31:0] freq_val = acc_inc * scale;
  wire        tot_evt = (mode_sel == `HSC_M_RISE) ? rise : fall;
  wire [31:0] tot_inc = value_reg + 32'h1;

  always @* begin
    gate  = scan_tick;
    scale = `HSC_SCALE_1S;
    case (mode_sel)
      `HSC_M_G1S: begin
        gate  = tick_1s;
        scale = `HSC_SCALE_1S;
      end
      `HSC_M_G100MS: begin
        gate  = tick_100ms;
        scale = `HSC_SCALE_100MS;
      end
      `HSC_M_G10MS: begin
        gate  = tick_10ms;
        scale = `HSC_SCALE_10MS;
      end
      default: begin
        gate  = scan_tick;
        scale = `HSC_SCALE_1S;
      end
    endcase
  end

  always @* begin
    meas_on = 1'b1;
    end_evt = rise;
    case (mode_sel)
      `HSC_M_WHIGH: begin
        meas_on = lvl;
        end_evt = fall;
      end
      `HSC_M_WLOW: begin
        meas_on = ~lvl;
        end_evt = rise;
      end
      `HSC_M_PFALL: begin
        meas_on = 1'b1;
        end_evt = fall;
      end
      default: begin
        meas_on = 1'b1;
        end_evt = rise;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      value_reg <= 32'h0;
      acc_reg   <= 32'h0;
    end else begin
      case (type_sel)
        `HSC_T_FREQ: begin
          if (gate) begin
            value_reg <= freq_val;
            acc_reg   <= 32'h0;
          end else begin
            acc_reg <= acc_inc;
          end
        end
        `HSC_T_TOT: begin
          acc_reg <= 32'h0;
          if (tot_evt) begin
            if ((cpr != 32'h0) && (tot_inc >= cpr)) begin
              value_reg <= 32'h0;
            end else begin
              value_reg <= tot_inc;
            end
          end
        end
        `HSC_T_PULSE: begin
          if (end_evt) begin
            value_reg <= acc_reg;
            // A tick on the closing cycle opens the next interval, so periods lose no count.
            acc_reg   <= {31'h0, meas_on & us_tick};
          end else if (meas_on && us_tick) begin
            acc_reg <= acc_reg + 32'h1;
          end
        end
        default: begin
          value_reg <= 32'h0;
          acc_reg   <= 32'h0;
        end
      endcase
    end
  end

endmodule // hsc_chan

/* File: hdl/hsc_bank.v */
// Purpose: Bank of four high-speed counters on the discrete inputs.
// Assumes: Inputs synchronous to sys_clk; scan_tick pulses once per program scan.
// Notes:   Counter 1 in quadrature uses inputs 1 and 2; input 3 may act as marker.
`timescale 1ns/1ps
`include "hsc_consts.vh"

// Operation
// - Four independent counters, each with own type, mode and counts-per-rev.
// - Inputs selectable active high or active low; levels interpreted accordingly.
// - Six types: disabled, frequency, totalize, pulse, quadrature, marker.
// - Disabled counter input appears as a plain discrete image bit.
// - Frequency gate is 1 s, 100 ms, 10 ms or one scan.
// - Pulse measures high width, low width or period, in microseconds.
// - Marker only on counter 3 while counter 1 is quadrature.
// - Marker resets quadrature on its edge or a phase edge qualified by level.
// - Counts-per-rev used by totalize and quadrature only.
module hsc_bank #(
  parameter GATE_10MS_CYC = `HSC_G10MS_NS / `HSC_CLK_NS
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         reset_n,
  // Discrete inputs
  input  wire [3:0]   hsc_in,
  input  wire         input_active_low,
  input  wire         scan_tick,
  // Configuration, four fields per bus, counter 1 in the low bits
  input  wire [11:0]  type_sel,
  input  wire [15:0]  mode_sel,
  input  wire [127:0] counts_per_rev,
  // Results
  output reg  [127:0] high_speed_counter,
  output reg  [3:0]   discrete_input_image_bit
);

  localparam US_CYC = `HSC_US_NS / `HSC_CLK_NS;

  reg  [3:0]   lvl_reg;
  reg  [3:0]   lvl_prev_reg;
  reg  [31:0]  us_cnt_reg;
  reg  [31:0]  g10_cnt_reg;
  reg  [3:0]   dec100_reg;
  reg  [3:0]   dec1s_reg;
  reg          us_tick_reg;
  reg          t10_reg;
  reg          t100_reg;
  reg          t1s_reg;
  reg  [31:0]  quad_reg;
  reg  [31:0]  quad_next;
  reg          mark_hit;
  wire [127:0] chan_val;

  // Phase and marker views of the corrected inputs.
  wire         p1      = lvl_reg[0];
  wire         p2      = lvl_reg[1];
  wire         p1_prev = lvl_prev_reg[0];
  wire         p2_prev = lvl_prev_reg[1];
  wire         mk      = lvl_reg[`HSC_MARK_CH];
  wire         mk_prev = lvl_prev_reg[`HSC_MARK_CH];
  wire         p1_r    = p1 & ~p1_prev;
  wire         p1_f    = ~p1 & p1_prev;
  wire         p2_r    = p2 & ~p2_prev;
  wire         p2_f    = ~p2 & p2_prev;
  wire         mk_r    = mk & ~mk_prev;
  wire         mk_f    = ~mk & mk_prev;

  wire [2:0]   q_type  = type_sel[2:0];
  wire [3:0]   q_mode  = mode_sel[3:0];
  wire [31:0]  q_cpr   = counts_per_rev[31:0];
  wire [2:0]   m_type  = type_sel[3*`HSC_MARK_CH +: 3];
  wire [3:0]   m_mode  = mode_sel[4*`HSC_MARK_CH +: 4];
  wire         quad_on = (q_type == `HSC_T_QUAD);
  wire         mark_on = quad_on && (m_type == `HSC_T_MARK);

  // A step occurs on any single phase transition; lead decides direction.
  wire         q_step  = p1 ^ p1_prev ^ p2 ^ p2_prev;
  wire         q_lead1 = ~(p1_prev ^ p2);
  wire         q_up    = q_lead1 ^ (q_mode == `HSC_M_QDOWN);
  wire [31:0]  q_inc   = quad_reg + 32'h1;

  // Input polarity and edge history.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      lvl_reg      <= 4'h0;
      lvl_prev_reg <= 4'h0;
    end else begin
      lvl_reg      <= hsc_in ^ {4{input_active_low}};
      lvl_prev_reg <= lvl_reg;
    end
  end

  // Microsecond tick and the decade gate chain.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      us_cnt_reg  <= 32'h0;
      g10_cnt_reg <= 32'h0;
      dec100_reg  <= 4'h0;
      dec1s_reg   <= 4'h0;
      us_tick_reg <= 1'b0;
      t10_reg     <= 1'b0;
      t100_reg    <= 1'b0;
      t1s_reg     <= 1'b0;
    end else begin
      us_tick_reg <= 1'b0;
      t10_reg     <= 1'b0;
      t100_reg    <= 1'b0;
      t1s_reg     <= 1'b0;
      if (us_cnt_reg == US_CYC - 1) begin
        us_cnt_reg  <= 32'h0;
        us_tick_reg <= 1'b1;
      end else begin
        us_cnt_reg <= us_cnt_reg + 32'h1;
      end
      if (g10_cnt_reg == GATE_10MS_CYC - 1) begin
        g10_cnt_reg <= 32'h0;
        t10_reg     <= 1'b1;
        if (dec100_reg == `HSC_DECADE) begin
          dec100_reg <= 4'h0;
          t100_reg   <= 1'b1;
          if (dec1s_reg == `HSC_DECADE) begin
            dec1s_reg <= 4'h0;
            t1s_reg   <= 1'b1;
          end else begin
            dec1s_reg <= dec1s_reg + 4'h1;
          end
        end else begin
          dec100_reg <= dec100_reg + 4'h1;
        end
      end else begin
        g10_cnt_reg <= g10_cnt_reg + 32'h1;
      end
    end
  end

  // Marker reset event.
  always @* begin
    mark_hit = 1'b0;
    case (m_mode)
      `HSC_M_ARISE: mark_hit = mk_r;
      `HSC_M_AFALL: mark_hit = mk_f;
      `HSC_M_ABOTH: mark_hit = mk_r | mk_f;
      `HSC_M_H1R:   mark_hit = mk & p1_r;
      `HSC_M_L1R:   mark_hit = ~mk & p1_r;
      `HSC_M_H1F:   mark_hit = mk & p1_f;
      `HSC_M_L1F:   mark_hit = ~mk & p1_f;
      `HSC_M_H2R:   mark_hit = mk & p2_r;
      `HSC_M_L2R:   mark_hit = ~mk & p2_r;
      `HSC_M_H2F:   mark_hit = mk & p2_f;
      `HSC_M_L2F:   mark_hit = ~mk & p2_f;
      default:      mark_hit = 1'b0;
    endcase
  end

  // Quadrature count with optional wrap at counts-per-rev.
  always @* begin
    quad_next = quad_reg;
    if (!quad_on) begin
      quad_next = 32'h0;
    end else if (mark_on && mark_hit) begin
      quad_next = 32'h0;
    end else if (q_step) begin
      if (q_up) begin
        if ((q_cpr != 32'h0) && (q_inc >= q_cpr)) begin
          quad_next = 32'h0;
        end else begin
          quad_next = q_inc;
        end
      end else if (quad_reg == 32'h0) begin
        quad_next = (q_cpr != 32'h0) ? q_cpr - 32'h1 : 32'hffffffff;
      end else begin
        quad_next = quad_reg - 32'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      quad_reg <= 32'h0;
    end else begin
      quad_reg <= quad_next;
    end
  end

  // One channel per counter; each keeps its own configuration.
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_chan
      hsc_chan u_chan (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .lvl        (lvl_reg[i]),
        .lvl_prev   (lvl_prev_reg[i]),
        .us_tick    (us_tick_reg),
        .tick_10ms  (t10_reg),
        .tick_100ms (t100_reg),
        .tick_1s    (t1s_reg),
        .scan_tick  (scan_tick),
        .type_sel   (type_sel[3*i +: 3]),
        .mode_sel   (mode_sel[4*i +: 4]),
        .cpr        (counts_per_rev[32*i +: 32]),
        .value_reg  (chan_val[32*i +: 32])
      );

      always @(posedge sys_clk) begin
        if (!reset_n) begin
          high_speed_counter[32*i +: 32] <= 32'h0;
          discrete_input_image_bit[i]    <= 1'b0;
        end else begin
          if ((i == `HSC_QUAD_CH) && quad_on) begin
            high_speed_counter[32*i +: 32] <= quad_reg;
          end else begin
            high_speed_counter[32*i +: 32] <= chan_val[32*i +: 32];
          end
          discrete_input_image_bit[i] <= (type_sel[3*i +: 3] == `HSC_T_DIS) & lvl_reg[i];
        end
      end
    end
  endgenerate

endmodule // hsc_bank

/* File: verif/hsc_src.sv */
// Purpose: Pulse source and encoder model on the discrete inputs.
// Assumes: Pins change 1 ns after a clock edge.
// Notes:   A set bit of wave_en runs a square wave of four cycles per period.
`timescale 1ns/1ps
module hsc_src (
  // Clock and wave control
  input  wire       sys_clk,
  input  wire [3:0] wave_en,
  // Discrete inputs
  output wire [3:0] pins
);
  reg       ph = 1'b0;
  reg       wave = 1'b0;
  reg [3:0] base = 4'h0;
  reg [1:0] qs = 2'h0;
  // Task levels and the free-running wave meet only here, so each pin has one driver.
  assign pins = base ^ ({4{wave}} & wave_en);
  always @(posedge sys_clk) begin
    ph <= ~ph;
    if (ph)
      wave <= #1 ~wave;
  end
  task set(input [3:0] mask, input [3:0] v);
    @(posedge sys_clk) #1 base = (base & ~mask) | (v & mask);
  endtask
  task pulse(input integer b, input integer hi, input integer lo);
    begin
      @(posedge sys_clk) #1 base[b] = 1'b1;
      repeat (hi) @(posedge sys_clk);
      #1 base[b] = 1'b0;
      repeat (lo - 1) @(posedge sys_clk);
    end
  endtask
  // Gray order 00, 01, 11, 10 puts phase 1 ahead when stepping forward.
  task step(input integer n, input integer fwd);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge sys_clk) #1 qs = fwd ? qs + 2'h1 : qs - 2'h1;
        base[1:0] = {qs[1], qs[1] ^ qs[0]};
      end
    end
  endtask
endmodule // hsc_src

/* File: verif/hsc_bank_sva.sv */
// Purpose: Port checks for the counter bank.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Results trail an input change by three edges, the image by two.
`timescale 1ns/1ps
`include "hsc_consts.vh"
module hsc_bank_sva #(
  parameter GATE_10MS_CYC = 100000
) (
  // Clock and reset
  input wire         sys_clk,
  input wire         reset_n,
  // Inputs
  input wire [3:0]   hsc_in,
  input wire         input_active_low,
  input wire         scan_tick,
  input wire [11:0]  type_sel,
  input wire [15:0]  mode_sel,
  input wire [127:0] counts_per_rev,
  // Results
  input wire [127:0] high_speed_counter,
  input wire [3:0]   discrete_input_image_bit
);
  wire [31:0] cnt1 = high_speed_counter[31:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_tot;
    type_sel[2:0] == `HSC_T_TOT && mode_sel[3:0] == `HSC_M_RISE
      && counts_per_rev[31:0] == 32'h0 && !input_active_low;
  endsequence
  sequence s_quad;
    type_sel[2:0] == `HSC_T_QUAD && mode_sel[3:0] == `HSC_M_QUP && !input_active_low
      && counts_per_rev[31:0] == 32'h0 && type_sel[8:6] != `HSC_T_MARK;
  endsequence
  property p_clear;
    $rose(reset_n) |-> high_speed_counter == 128'h0 && discrete_input_image_bit == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("outputs not clear");
  property p_image;
    (type_sel[2:0] == `HSC_T_DIS) [*3] |-> discrete_input_image_bit[0]
      == ($past(hsc_in[0], 2) ^ $past(input_active_low, 2));
  endproperty
  a_image: assert property (p_image) else $error("image bit wrong");
  property p_img_off;
    (type_sel[2:0] != `HSC_T_DIS) [*2] |-> discrete_input_image_bit[0] == 1'b0;
  endproperty
  a_img_off: assert property (p_img_off) else $error("image bit set");
  property p_tot_rise;
    s_tot ##0 $rose(hsc_in[0]) |-> ##3 cnt1 == $past(cnt1) + 32'h1;
  endproperty
  a_tot_rise: assert property (p_tot_rise) else $error("rise not counted");
  property p_tot_fall;
    s_tot ##0 $fell(hsc_in[0]) |-> ##3 $stable(cnt1);
  endproperty
  a_tot_fall: assert property (p_tot_fall) else $error("fall counted");
  property p_quad_up;
    s_quad ##0 ($rose(hsc_in[0]) && !hsc_in[1]) |-> ##3 cnt1 == $past(cnt1) + 32'h1;
  endproperty
  a_quad_up: assert property (p_quad_up) else $error("quadrature not up");
  property p_marker;
    type_sel[2:0] == `HSC_T_QUAD && type_sel[8:6] == `HSC_T_MARK && !input_active_low
      && mode_sel[11:8] == `HSC_M_ARISE && $rose(hsc_in[2]) |-> ##3 cnt1 == 32'h0;
  endproperty
  a_marker: assert property (p_marker) else $error("marker no reset");
  property p_mark_zero;
    (type_sel[8:6] == `HSC_T_MARK) [*3] |-> high_speed_counter[95:64] == 32'h0;
  endproperty
  a_mark_zero: assert property (p_mark_zero) else $error("marker value");
endmodule // hsc_bank_sva
bind hsc_bank hsc_bank_sva #(.GATE_10MS_CYC(GATE_10MS_CYC)) i_hsc_bank_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .hsc_in(hsc_in),
  .input_active_low(input_active_low), .scan_tick(scan_tick), .type_sel(type_sel),
  .mode_sel(mode_sel), .counts_per_rev(counts_per_rev),
  .high_speed_counter(high_speed_counter),
  .discrete_input_image_bit(discrete_input_image_bit));

/* File: verif/tb_hsc_bank.sv */
// Purpose: Self-checking bench for the counter bank.
// Assumes: 10 ms gate shortened to 20 cycles.
// Notes:   Inputs change 1 ns after a rising edge.
`timescale 1ns/1ps
`include "hsc_consts.vh"
module tb_hsc_bank;
  reg          sys_clk = 1'b0;
  reg          reset_n = 1'b0;
  reg          input_active_low = 1'b0;
  reg          scan_tick = 1'b0;
  reg  [11:0]  type_sel = 12'h0;
  reg  [15:0]  mode_sel = 16'h0;
  reg  [127:0] counts_per_rev = 128'h0;
  reg  [3:0]   wave_en = 4'h0;
  reg  [31:0]  ev;
  wire [3:0]   hsc_in;
  wire [127:0] high_speed_counter;
  wire [3:0]   discrete_input_image_bit;
  integer      failures = 0;
  integer      cmp_count = 0;
  integer      cycles = 0;
  integer      m;
  integer      k;
  hsc_bank #(.GATE_10MS_CYC(20)) i_hsc_bank (.sys_clk(sys_clk), .reset_n(reset_n),
    .hsc_in(hsc_in), .input_active_low(input_active_low), .scan_tick(scan_tick),
    .type_sel(type_sel), .mode_sel(mode_sel), .counts_per_rev(counts_per_rev),
    .high_speed_counter(high_speed_counter),
    .discrete_input_image_bit(discrete_input_image_bit));
  hsc_src i_hsc_src (.sys_clk(sys_clk), .wave_en(wave_en), .pins(hsc_in));
  initial forever #50 sys_clk = ~sys_clk;
  task chk(input [47:0] what, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cfg(input integer c, input [2:0] t, input [3:0] md, input [31:0] cp);
    begin
      @(posedge sys_clk) #1;
      type_sel[c*3 +: 3] = t;
      mode_sel[c*4 +: 4] = md;
      counts_per_rev[c*32 +: 32] = cp;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results;
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    i_hsc_src.set(4'hf, 4'h5);
    repeat (3) @(posedge sys_clk);
    chk("image", {28'h0, discrete_input_image_bit}, 32'h5);
    #1 input_active_low = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("inv", {28'h0, discrete_input_image_bit}, 32'ha);
    #1 input_active_low = 1'b0;
    i_hsc_src.set(4'hf, 4'h0);
    $display("test image done");
    cfg(0, `HSC_T_TOT, `HSC_M_RISE, 32'h0);
    cfg(1, `HSC_T_TOT, `HSC_M_FALL, 32'h3);
    cfg(2, `HSC_T_TOT, `HSC_M_RISE, 32'hffffffff);
    for (k = 0; k < 5; k = k + 1) begin
      i_hsc_src.set(4'hf, 4'hf);
      i_hsc_src.set(4'hf, 4'h0);
    end
    repeat (5) @(posedge sys_clk);
    chk("tot1", high_speed_counter[31:0], 32'h5);
    chk("tot2", high_speed_counter[63:32], 32'h2);
    chk("tot3", high_speed_counter[95:64], 32'h5);
    $display("test totalize done");
    #1 wave_en = 4'h8;
    for (m = 0; m < 3; m = m + 1) begin
      cfg(3, `HSC_T_FREQ, m[3:0], 32'h1);
      repeat (40 * (m == 0 ? 100 : (m == 1 ? 10 : 1)) + 10) @(posedge sys_clk);
      chk("freq", high_speed_counter[127:96], 32'h1f4);
    end
    cfg(3, `HSC_T_FREQ, `HSC_M_GSCAN, 32'h0);
    for (k = 0; k < 3; k = k + 1) begin
      repeat (39) @(posedge sys_clk);
      #1 scan_tick = 1'b1;
      @(posedge sys_clk) #1 scan_tick = 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    chk("scan", high_speed_counter[127:96], 32'ha);
    #1 wave_en = 4'h0;
    $display("test frequency done");
    for (m = 0; m < 4; m = m + 1) begin
      cfg(1, `HSC_T_PULSE, m[3:0], 32'h0);
      for (k = 0; k < 3; k = k + 1)
        i_hsc_src.pulse(1, 50, 30);
      repeat (5) @(posedge sys_clk);
      ev = m == 0 ? 32'h5 : (m == 1 ? 32'h3 : 32'h8);
      chk("pulse", high_speed_counter[63:32], ev);
    end
    $display("test pulse done");
    cfg(0, `HSC_T_QUAD, `HSC_M_QUP, 32'h0);
    for (m = 0; m < 3; m = m + 1) begin
      cfg(2, `HSC_T_MARK, m[3:0], 32'h0);
      i_hsc_src.step(3, 1);
      i_hsc_src.pulse(2, 2, 2);
      repeat (4) @(posedge sys_clk);
      chk("async", high_speed_counter[31:0], 32'h0);
    end
    cfg(2, `HSC_T_DIS, 4'h0, 32'h0);
    i_hsc_src.step(7, 1);
    i_hsc_src.step(10, 0);
    repeat (4) @(posedge sys_clk);
    chk("quad", high_speed_counter[31:0], 32'hfffffffd);
    cfg(0, `HSC_T_QUAD, `HSC_M_QDOWN, 32'h0);
    i_hsc_src.step(2, 1);
    repeat (4) @(posedge sys_clk);
    chk("qdown", high_speed_counter[31:0], 32'hfffffffb);
    cfg(0, `HSC_T_QUAD, `HSC_M_QUP, 32'h8);
    cfg(2, `HSC_T_MARK, `HSC_M_ARISE, 32'h0);
    i_hsc_src.pulse(2, 2, 2);
    i_hsc_src.step(10, 1);
    repeat (4) @(posedge sys_clk);
    chk("wrap", high_speed_counter[31:0], 32'h2);
    i_hsc_src.step(2, 1);
    for (m = 3; m < 11; m = m + 1) begin
      cfg(2, `HSC_T_MARK, m[3:0], 32'h0);
      i_hsc_src.set(4'h4, m[0] ? 4'h4 : 4'h0);
      i_hsc_src.step(4, 1);
      repeat (4) @(posedge sys_clk);
      ev = m < 5 ? 32'h3 : (m < 7 ? 32'h1 : (m < 9 ? 32'h2 : 32'h0));
      chk("qual", high_speed_counter[31:0], ev);
    end
    $display("test quadrature done");
    results;
  end
endmodule // tb_hsc_bank
